// [logic/tcr_tone_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module tcr_tone_regs
    import tcr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = TCR_DEV_ADDR_DEF
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control port pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Tone settings toward the audio path
    output logic [7:0] low_shelf_code,
    output logic [7:0] high_shelf_code,
    output logic [7:0] loud_gain_code,
    output logic [7:0] loud_mode_code,
    output logic ref_at_2khz,
    output logic bass_corner_high,
    output logic loudness_active
);
    tcr_state_t state;
    tcr_state_t next_state;
    logic start_seen;
    logic stop_seen;
    logic byte_valid;
    logic [7:0] byte_data;
    logic [7:0] reg_hi;
    logic [15:0] reg_num;
    logic [7:0] data_hi;
    logic [15:0] low_shelf_gain;
    logic [15:0] high_shelf_gain;
    logic [15:0] loudness_contour;

    // Address zero is the general call and can never be this device.
    if (DEV_ADDR == 7'h00)
    begin : g_bad_addr
        $error("tcr_tone_regs: device address 0 is the general call");
    end

    // ****************************************************************
    // Byte receiver
    // ****************************************************************
    wire dev_match = byte_data == {DEV_ADDR, 1'b0};
    wire sub_match = byte_data == TCR_SUB_CODEC_WR;
    wire ack_ok = (state == TCR_DEV) ? dev_match :
        (state == TCR_SUB) ? sub_match :
        (state != TCR_SKIP) && (state != TCR_IDLE);

    tcr_byte_rx u_rx (
        .clk(clk),
        .rstn(rstn),
        .scl(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .ack_ok(ack_ok),
        .start_seen(start_seen),
        .stop_seen(stop_seen),
        .byte_valid(byte_valid),
        .byte_data(byte_data)
    );

    // ****************************************************************
    // Transaction sequencing
    // ****************************************************************
    wire commit = byte_valid && (state == TCR_DAT_LO);
    wire [15:0] data_word = {data_hi, byte_data};
    wire hit_low = commit && (reg_num == TCR_REG_LOW_SHELF);
    wire hit_high = commit && (reg_num == TCR_REG_HIGH_SHELF);
    wire hit_loud = commit && (reg_num == TCR_REG_LOUDNESS);
    wire [7:0] new_mode = data_word[TCR_MODE_MSB:TCR_MODE_LSB];
    wire [7:0] new_loud = data_word[TCR_GAIN_MSB:TCR_GAIN_LSB];

    always_comb
    begin
        next_state = state;
        if (byte_valid)
        begin
            case (state)
                TCR_DEV: next_state = dev_match ? TCR_SUB : TCR_SKIP;
                TCR_SUB: next_state = sub_match ? TCR_REG_HI : TCR_SKIP;
                TCR_REG_HI: next_state = TCR_REG_LO;
                TCR_REG_LO: next_state = TCR_DAT_HI;
                TCR_DAT_HI: next_state = TCR_DAT_LO;
                TCR_DAT_LO: next_state = TCR_SKIP;
                default: next_state = state;
            endcase
        end
        if (start_seen)
        begin
            next_state = TCR_DEV;
        end
        else if (stop_seen)
        begin
            next_state = TCR_IDLE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= TCR_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk)
    begin
        if (byte_valid && state == TCR_REG_HI)
        begin
            reg_hi <= byte_data;
        end
        if (byte_valid && state == TCR_REG_LO)
        begin
            reg_num <= {reg_hi, byte_data};
        end
        if (byte_valid && state == TCR_DAT_HI)
        begin
            data_hi <= byte_data;
        end
    end

    // ****************************************************************
    // Tone registers
    // ****************************************************************
    // Gains go out exactly as written; headroom is the host's concern.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            low_shelf_gain <= TCR_RST_WORD;
            high_shelf_gain <= TCR_RST_WORD;
            loudness_contour <= TCR_RST_WORD;
        end
        else
        begin
            if (hit_low)
            begin
                low_shelf_gain <= data_word;
            end
            if (hit_high)
            begin
                high_shelf_gain <= data_word;
            end
            if (hit_loud)
            begin
                loudness_contour <= data_word;
            end
        end
    end

    assign low_shelf_code = low_shelf_gain[TCR_GAIN_MSB:TCR_GAIN_LSB];
    assign high_shelf_code = high_shelf_gain[TCR_GAIN_MSB:TCR_GAIN_LSB];
    assign loud_gain_code = loudness_contour[TCR_GAIN_MSB:TCR_GAIN_LSB];
    assign loud_mode_code = loudness_contour[TCR_MODE_MSB:TCR_MODE_LSB];

    // ****************************************************************
    // Loudness contour controls
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ref_at_2khz <= 1'b0;
            bass_corner_high <= 1'b0;
            loudness_active <= 1'b0;
        end
        else if (hit_loud)
        begin
            ref_at_2khz <= new_mode == TCR_MODE_SHIFTED;
            bass_corner_high <= new_mode == TCR_MODE_SHIFTED;
            loudness_active <= new_loud != TCR_CODE_ZERO;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_low_write;
        hit_low;
    endsequence
    sequence s_high_write;
        hit_high;
    endsequence
    sequence s_loud_write;
        hit_loud;
    endsequence
    sequence s_value_bytes;
        (byte_valid && state == TCR_DAT_HI) ##1 (state == TCR_DAT_LO);
    endsequence

    a_low_gain_load: assert property (
        s_low_write |=> low_shelf_code == $past(data_word[15:8]))
        else $error("low shelf code not loaded");
    a_high_gain_load: assert property (
        s_high_write |=> high_shelf_code == $past(data_word[15:8]))
        else $error("high shelf code not loaded");
    a_gain_unguarded: assert property (
        $changed(low_shelf_code) || $changed(high_shelf_code)
        |-> $past(hit_low) || $past(hit_high))
        else $error("gain moved without a write");
    a_loud_gain_load: assert property (
        s_loud_write |=> loud_gain_code == $past(new_loud))
        else $error("loudness gain not loaded");
    a_loud_mode_ref: assert property (
        s_loud_write |=> ref_at_2khz == ($past(new_mode) == TCR_MODE_SHIFTED))
        else $error("reference point mismatch");
    a_corner_shift: assert property (
        bass_corner_high == (loud_mode_code == 8'h04))
        else $error("corner shift mismatch");
    a_loud_active: assert property (
        loudness_active == (loud_gain_code != 8'h00))
        else $error("loudness enable mismatch");
    a_whole_word: assert property (
        commit |-> $past(state) == TCR_DAT_LO)
        else $error("commit without both value bytes");
    a_low_byte_wait: assert property (
        s_value_bytes |=> !commit [*8])
        else $error("commit before the low value byte");
    a_regs_hold: assert property (
        !$past(commit) |-> $stable(low_shelf_gain) &&
        $stable(high_shelf_gain) && $stable(loudness_contour))
        else $error("register changed mid transfer");
endmodule // tcr_tone_regs
`default_nettype wire

// [include/tcr_pkg.sv]
package tcr_pkg;

    // ****************************************************************
    // Control port codes
    // ****************************************************************
    localparam logic [6:0] TCR_DEV_ADDR_DEF = 7'h1d;
    localparam logic [7:0] TCR_SUB_CODEC_WR = 8'h6c;

    // ****************************************************************
    // Register numbers
    // ****************************************************************
    localparam logic [15:0] TCR_REG_LOW_SHELF = 16'h0014;
    localparam logic [15:0] TCR_REG_HIGH_SHELF = 16'h0015;
    localparam logic [15:0] TCR_REG_LOUDNESS = 16'h001e;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int TCR_GAIN_MSB = 15;
    localparam int TCR_GAIN_LSB = 8;
    localparam int TCR_MODE_MSB = 7;
    localparam int TCR_MODE_LSB = 0;
    localparam logic [15:0] TCR_RST_WORD = 16'h0000;
    localparam logic [7:0] TCR_MODE_NORMAL = 8'h00;
    localparam logic [7:0] TCR_MODE_SHIFTED = 8'h04;
    localparam logic [7:0] TCR_CODE_ZERO = 8'h00;
    localparam logic [3:0] TCR_BITS_PER_BYTE = 4'h8;

    // ****************************************************************
    // Transaction states
    // ****************************************************************
    typedef enum logic [2:0] {
        TCR_IDLE,
        TCR_DEV,
        TCR_SUB,
        TCR_REG_HI,
        TCR_REG_LO,
        TCR_DAT_HI,
        TCR_DAT_LO,
        TCR_SKIP
    } tcr_state_t;

endpackage

// [logic/tcr_byte_rx.sv]
`timescale 1ns/100ps
`default_nettype none
module tcr_byte_rx
    import tcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Byte side
    input wire logic ack_ok,
    output logic start_seen,
    output logic stop_seen,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    logic scl_q;
    logic sda_q;
    logic active;
    logic ack_phase;
    logic ack_lat;
    logic [3:0] bit_cnt;

    // ****************************************************************
    // Line event decode
    // ****************************************************************
    wire is_start = scl_q && scl && sda_q && !sda_in;
    wire is_stop = scl_q && scl && !sda_q && sda_in;
    wire scl_rise = !scl_q && scl;
    wire scl_fall = scl_q && !scl;
    wire data_bit = active && !ack_phase && scl_rise &&
        (bit_cnt < TCR_BITS_PER_BYTE);
    wire last_bit = data_bit && (bit_cnt == TCR_BITS_PER_BYTE - 4'h1);
    wire ack_begin = active && !ack_phase && scl_fall &&
        (bit_cnt == TCR_BITS_PER_BYTE);
    wire ack_end = active && ack_phase && scl_fall;

    assign sda_out = 1'b0;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // ****************************************************************
    // Bit counting and acknowledge drive
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn || is_start || is_stop)
        begin
            active <= rstn && is_start;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
        end
        else if (data_bit)
        begin
            byte_data <= {byte_data[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
        end
        else if (ack_begin)
        begin
            ack_phase <= 1'b1;
            sda_oe <= ack_lat;
        end
        else if (ack_end)
        begin
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
            byte_valid <= 1'b0;
            ack_lat <= 1'b0;
        end
        else
        begin
            start_seen <= is_start;
            stop_seen <= is_stop;
            byte_valid <= last_bit;
            if (byte_valid)
            begin
                ack_lat <= ack_ok;
            end
        end
    end
endmodule // tcr_byte_rx
`default_nettype wire

// [test/tcr_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tcr_host_model
(
    // Clock
    input wire logic clk,
    // Bus pins
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ********************************************************
    // Bus idles released and high.
    // ********************************************************
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data is released first so that a repeated start is clean.
    task automatic start_bit;
        sda_low <= 1'b0;
        tk(2);
        scl <= 1'b1;
        tk(3);
        sda_low <= 1'b1;
        tk(3);
        scl <= 1'b0;
        tk(2);
    endtask

    task automatic stop_bit;
        sda_low <= 1'b1;
        tk(2);
        scl <= 1'b1;
        tk(3);
        sda_low <= 1'b0;
        tk(3);
    endtask

    // Data never moves on the edge where the clock falls.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_low <= !b[i];
            tk(2);
            scl <= 1'b1;
            tk(3);
            scl <= 1'b0;
            tk(1);
        end
        sda_low <= 1'b0;
        tk(3);
        scl <= 1'b1;
        tk(2);
        ack = !sda;
        scl <= 1'b0;
        tk(1);
    endtask

    // Sends n bytes from the left of b, then a stop.
    task automatic frame(input logic [55:0] b, input int n,
                         output logic [6:0] acks);
        acks = '0;
        start_bit();
        for (int i = 0; i < n; i++)
            send_byte(b[55 - 8 * i -: 8], acks[i]);
        stop_bit();
    endtask
endmodule // tcr_host_model
`default_nettype wire

// [test/tone_control_registers_test.sv]
`timescale 1ns/100ps
`default_nettype none
module tone_control_registers_test
    import tcr_pkg::*;
;
    logic clk, rstn, sda_low, sda_out, sda_oe, ref2k, corner, active;
    wire logic scl;
    wire logic sda;
    logic [7:0] low, high, lg, mode, e_low, e_high, e_lg, e_mode;
    logic [7:0] a0;
    logic [6:0] acks;
    int n_errors = 0;
    int checks_done = 0;
    // Register, value, then expected low, high, gain and mode codes.
    // The last rows keep headroom at 0 dB and retune loudness with volume.
    logic [63:0] rows [12] = '{
        64'h0014_6000_60_00_00_00, 64'h0014_a000_a0_00_00_00,
        64'h0015_6000_a0_60_00_00, 64'h0015_f800_a0_f8_00_00,
        64'h001e_4400_a0_f8_44_00, 64'h001e_0404_a0_f8_04_04,
        64'h001e_0003_a0_f8_00_03, 64'h0016_ffff_a0_f8_00_03,
        64'h0014_e000_e0_f8_00_03, 64'h0015_f000_e0_f0_00_03,
        64'h001e_0800_e0_f0_08_00, 64'h001e_0404_e0_f0_04_04};

    // The data line has a pull-up; either party may pull it low.
    assign sda = !(sda_low || (sda_oe && !sda_out));
    assign a0 = {TCR_DEV_ADDR_DEF, 1'b0};

    tcr_tone_regs uut (.clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .low_shelf_code(low),
        .high_shelf_code(high), .loud_gain_code(lg),
        .loud_mode_code(mode), .ref_at_2khz(ref2k),
        .bass_corner_high(corner), .loudness_active(active));
    tcr_host_model host (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));

    // ********************************************************
    // Checking and closing.
    // ********************************************************
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_outs;
        check("low_shelf_code", 16'(low), 16'(e_low));
        check("high_shelf_code", 16'(high), 16'(e_high));
        check("loud_gain_code", 16'(lg), 16'(e_lg));
        check("loud_mode_code", 16'(mode), 16'(e_mode));
        check("ref_at_2khz", 16'(ref2k), 16'(e_mode == 8'h04));
        check("corner", 16'(corner), 16'(e_mode == 8'h04));
        check("active", 16'(active), 16'(e_lg != 8'h00));
        check("sda_out", 16'(sda_out), 16'h0000);
        check("sda_oe", 16'(sda_oe), 16'h0000);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        $display("test watchdog expired");
        finish_test();
    end

    // ********************************************************
    // Main sequence.
    // ********************************************************
    initial
    begin
        rstn = 1'b0;
        {e_low, e_high, e_lg, e_mode} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        check_outs();
        $display("test reset done");
        // Shelf values carry zero in their low byte.
        for (int i = 0; i < 12; i++)
        begin
            host.frame({a0, TCR_SUB_CODEC_WR, rows[i][63:32], 8'h00},
                       6, acks);
            {e_low, e_high, e_lg, e_mode} = rows[i][31:0];
            check("acks", 16'(acks), 16'h003f);
            check_outs();
        end
        $display("test table done");
        // Read bit set in the address byte is refused.
        host.frame({a0 | 8'h01, TCR_SUB_CODEC_WR, 32'h0014_1100, 8'h00},
                   6, acks);
        check("acks", 16'(acks), 16'h0000);
        // The read subaddress is refused after the address.
        host.frame({a0, 8'h6d, 32'h0014_1100, 8'h00}, 6, acks);
        check("acks", 16'(acks), 16'h0001);
        // A stop after the first value byte drops the write.
        host.frame({a0, TCR_SUB_CODEC_WR, 32'h0014_1100, 8'h00}, 5, acks);
        check("acks", 16'(acks), 16'h001f);
        check_outs();
        $display("test refused frames done");
        // A surplus byte is refused but the whole word still lands.
        host.frame({a0, TCR_SUB_CODEC_WR, 32'h0015_2000, 8'h55}, 7, acks);
        e_high = 8'h20;
        check("acks", 16'(acks), 16'h003f);
        check_outs();
        $display("test surplus byte done");
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        {e_low, e_high, e_lg, e_mode} = '0;
        check_outs();
        $display("test second reset done");
        finish_test();
    end
endmodule // tone_control_registers_test
`default_nettype wire
